//--- rtl/cpp_map.svh
// Register offsets, reset values and timing figures of the channel logic
`ifndef CPP_MAP_SVH
`define CPP_MAP_SVH

`define CPP_OFS_OUTCTL  6'h00
`define CPP_OFS_PAIR    6'h01
`define CPP_OFS_INRUSH  6'h02
`define CPP_OFS_LCLR    6'h03
`define CPP_OFS_TRIM    6'h04
`define CPP_OFS_PWM0    6'h05
`define CPP_OFS_PWM1    6'h06
`define CPP_OFS_PWMOUT  6'h07
`define CPP_OFS_PWMMAP  6'h08
`define CPP_OFS_STATUS  6'h09

`define CPP_DUTY_LSB    0
`define CPP_DIV_LSB     8
`define CPP_ERR_LSB     8
`define CPP_LVL_LSB     16

`define CPP_TRIM_RST    4'h8
`define CPP_DIV_FULL    2'h3

`define CPP_CLK_HZ      25000000
`define CPP_FINT_HZ     102400
`define CPP_ACC_BITS    24
`define CPP_BIM_WIN_MS  40
`define CPP_RESTART_US  1000

`endif

//--- rtl/cpp_pkg.sv
// Types shared by the channel protection and PWM logic
package cpp_pkg;

   typedef enum logic [1:0] {
      CH_READY,
      CH_LATCHED,
      CH_WAIT
   } cpp_ch_e;

   typedef struct packed {
      logic [7:0]        out_cmd;
      logic [3:0]        par;
      logic [7:0]        bulb_inrush_mode;
      logic [3:0]        trim;
      logic [1:0][7:0]   duty;
      logic [1:0][1:0]   div;
      logic [1:0][7:0]   act_duty;
      logic [1:0][1:0]   act_div;
      logic [1:0][7:0]   cnt;
      logic [1:0][1:0]   pre;
      logic [1:0]        lvl;
      logic [23:0]       acc;
      logic [7:0]        pwm_out;
      logic [7:0]        pwm_map;
      logic [7:0]        cmd_q;
      cpp_ch_e [7:0]     ch;
      logic [7:0][19:0]  wtim;
      logic [7:0][19:0]  rtim;
      logic [7:0]        err;
      logic [7:0]        gate;
      logic              dp_wr;
      logic [5:0]        dp_idx;
      logic [31:0]       hrdata;
      logic              hready;
      logic              hresp;
   } cpp_state_s;

endpackage : cpp_pkg

//--- rtl/cpp_chan_ctrl.sv
// Channel protection coupling, inrush restart and two PWM generators
//
// The AHB-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "cpp_map.svh"

module cpp_chan_ctrl #(
   parameter int BIM_WIN_CYC =
      `CPP_BIM_WIN_MS * (`CPP_CLK_HZ / 1000),
   parameter int RESTART_CYC =
      `CPP_RESTART_US * (`CPP_CLK_HZ / 1000000)
) (
   input  wire logic        I_SYS_CLK,
   input  wire logic        I_RSTN,
   input  wire logic        I_HSEL,
   input  wire logic [31:0] I_HADDR,
   input  wire logic [1:0]  I_HTRANS,
   input  wire logic        I_HWRITE,
   input  wire logic [2:0]  I_HSIZE,
   input  wire logic [31:0] I_HWDATA,
   input  wire logic        I_HREADY,
   input  wire logic [7:0]  I_OVERLOAD,
   input  wire logic [7:0]  I_OVERTEMP,
   input  wire logic [7:0]  I_INVERSE,
   output logic      [31:0] O_HRDATA,
   output logic             O_HREADYOUT,
   output logic             O_HRESP,
   output logic      [7:0]  O_GATE,
   output logic      [7:0]  O_ERR
);
   import cpp_pkg::*;

   localparam longint NOM_STEP =
      (longint'(1) << `CPP_ACC_BITS) * `CPP_FINT_HZ / `CPP_CLK_HZ;

   cpp_state_s s;
   cpp_state_s next_s;
   logic [7:0] fault;
   logic [7:0] trip;
   logic [7:0] inv_hot;
   logic [7:0] err_set;
   logic [7:0] clr_req;
   logic [7:0] rst_done;
   logic [7:0] win_done;
   logic [7:0] chan_cmd;
   logic [7:0] sw_on;
   logic [7:0] sw_off;
   logic [1:0] gen_used;
   logic [1:0] gen_full;
   logic [1:0] gen_wrap;

   // Phase accumulator step at the nominal base frequency. A wider
   // accumulator would cut the rounding error of the step at some area
   // cost; the error here stays far below one trim step.
   // Trim code to accumulator step, in per mille of nominal
   function automatic logic [23:0] trim_step(input logic [3:0] code);
      int pm;
      pm = 0;
      unique case (code)
         4'h1: pm = -372;
         4'h2: pm = -319;
         4'h3: pm = -269;
         4'h4: pm = -210;
         4'h5: pm = -155;
         4'h6: pm = -109;
         4'h7: pm = -58;
         4'h9: pm = 43;
         4'ha: pm = 89;
         4'hb: pm = 140;
         4'hc: pm = 195;
         4'hd: pm = 256;
         4'he: pm = 324;
         4'hf: pm = 400;
         default: pm = 0; // Reserved 0000 runs nominal
      endcase
      return 24'(NOM_STEP + NOM_STEP * pm / 1000);
   endfunction : trim_step

   // Per channel fault detect and pair coupling
   for (genvar i = 0; i < 8; i++) begin : g_ch
      localparam int P = i ^ 2;
      localparam int B = (i / 4) * 2 + (i % 2);
      // Protection sleeps while reverse current flows
      assign fault[i] = s.gate[i] & ~I_INVERSE[i]
                      & (I_OVERLOAD[i] | I_OVERTEMP[i]);
      // Partner fault only forces a switch-off, never a switch-on
      assign trip[i] = fault[i]
                     | (s.par[B] & fault[P]);
      // Overheat under inverse current still flags a channel that is on
      assign inv_hot[i] = s.gate[i] & I_INVERSE[i] & I_OVERTEMP[i];
      // A partner trip flags only a channel that was itself on
      assign err_set[i] = (trip[i] & s.gate[i]) | inv_hot[i];
      // Latch clear lands in the data phase of a write to the clear word
      assign clr_req[i] = s.dp_wr & (s.dp_idx == `CPP_OFS_LCLR)
                        & I_HWDATA[i];
      // End of the restart delay and of the inrush window
      assign rst_done[i] = (s.rtim[i] >= 20'(RESTART_CYC - 1));
      assign win_done[i] = (s.wtim[i] >= 20'(BIM_WIN_CYC - 1));
      // Source select per channel; coupling never reaches this path
      assign chan_cmd[i] = s.pwm_out[i] ? s.lvl[s.pwm_map[i]]
                                        : s.out_cmd[i];
      // Command edges, whatever the source
      assign sw_on[i]  = chan_cmd[i] & ~s.cmd_q[i];
      assign sw_off[i] = ~chan_cmd[i] & s.cmd_q[i];
   end

   // Generator bookkeeping
   for (genvar g = 0; g < 2; g++) begin : g_gen
      // A generator is idle while no channel takes its level
      assign gen_used[g] = |(s.pwm_out & ((g == 0) ? ~s.pwm_map : s.pwm_map));
      assign gen_full[g] = (s.act_div[g] == `CPP_DIV_FULL);
      // Last step of the running period
      assign gen_wrap[g] = (s.cnt[g] == 8'hff);
   end

   // One combinational pass builds the whole next state. The bus slave has
   // no wait states: the address phase prepares read data, which stands for
   // the one data phase cycle and is zero otherwise; a write lands at the
   // edge that ends its data phase. Transfer size is not checked, so a
   // narrow write acts as a whole word write.
   always_comb begin
      logic       sel;
      logic       wr;
      logic       tick;
      logic       done;
      logic       stp;
      logic       cmd;
      logic [31:0] wd;
      logic [1:0] lim;

      next_s = s;
      sel  = I_HSEL & I_HTRANS[1] & I_HREADY;
      wr   = s.dp_wr;
      wd   = I_HWDATA;
      tick = 1'b0;
      done = 1'b0;
      stp  = 1'b0;
      cmd  = 1'b0;
      lim  = 2'h0;

      // Bus address phase; read data is prepared for the data phase
      next_s.dp_wr  = sel & I_HWRITE;
      next_s.dp_idx = I_HADDR[7:2];
      next_s.hready = 1'b1;
      next_s.hresp  = 1'b0;
      next_s.hrdata = 32'h0;
      if (sel & ~I_HWRITE) begin
         unique case (I_HADDR[7:2])
            `CPP_OFS_OUTCTL: begin
               next_s.hrdata[7:0] = s.out_cmd;
            end
            `CPP_OFS_PAIR: begin
               next_s.hrdata[3:0] = s.par;
            end
            `CPP_OFS_INRUSH: begin
               next_s.hrdata[7:0] = s.bulb_inrush_mode;
            end
            `CPP_OFS_LCLR: begin
               for (int i = 0; i < 8; i++) begin
                  next_s.hrdata[i] = (s.ch[i] == CH_LATCHED);
               end
            end
            `CPP_OFS_TRIM: begin
               next_s.hrdata[3:0] = s.trim;
            end
            `CPP_OFS_PWM0: begin
               next_s.hrdata[9:0] = {s.div[0], s.duty[0]};
            end
            `CPP_OFS_PWM1: begin
               next_s.hrdata[9:0] = {s.div[1], s.duty[1]};
            end
            `CPP_OFS_PWMOUT: begin
               next_s.hrdata[7:0] = s.pwm_out;
            end
            `CPP_OFS_PWMMAP: begin
               next_s.hrdata[7:0] = s.pwm_map;
            end
            `CPP_OFS_STATUS: begin
               next_s.hrdata[7:0] = s.gate;
               next_s.hrdata[`CPP_ERR_LSB +: 8] = s.err;
               next_s.hrdata[`CPP_LVL_LSB +: 2] = s.lvl;
            end
            default: next_s.hrdata = 32'h0;
         endcase
      end

      // Bus data phase writes to configuration
      if (wr) begin
         unique case (s.dp_idx)
            `CPP_OFS_OUTCTL: begin
               next_s.out_cmd = wd[7:0];
            end
            `CPP_OFS_PAIR: begin
               next_s.par = wd[3:0];
            end
            `CPP_OFS_TRIM: begin
               next_s.trim = wd[3:0];
            end
            `CPP_OFS_PWM0: begin
               next_s.duty[0] = wd[`CPP_DUTY_LSB +: 8];
               next_s.div[0]  = wd[`CPP_DIV_LSB +: 2];
            end
            `CPP_OFS_PWM1: begin
               next_s.duty[1] = wd[`CPP_DUTY_LSB +: 8];
               next_s.div[1]  = wd[`CPP_DIV_LSB +: 2];
            end
            `CPP_OFS_PWMOUT: begin
               next_s.pwm_out = wd[7:0];
            end
            `CPP_OFS_PWMMAP: begin
               next_s.pwm_map = wd[7:0];
            end
            `CPP_OFS_STATUS: begin
               next_s.err = s.err & ~wd[`CPP_ERR_LSB +: 8];
            end
            default: ;
         endcase
      end

      // Shared base oscillator as a phase accumulator
      {tick, next_s.acc} = {1'b0, s.acc}
                         + {1'b0, trim_step(s.trim)};

      // Each generator counts prescaled base ticks through a 256 step period.
      // Divider codes 00, 01 and 10 take every fourth, second or every tick;
      // code 11 holds the level high and reloads on each tick instead.
      for (int g = 0; g < 2; g++) begin
         unique case (s.act_div[g])
            2'h0: begin
               lim = 2'h3;
            end
            2'h1: begin
               lim = 2'h1;
            end
            default: begin
               lim = 2'h0;
            end
         endcase
         done = (s.pre[g] == lim);
         stp  = tick & done;
         if (tick) begin
            next_s.pre[g] = done ? 2'h0 : s.pre[g] + 2'h1;
         end
         if (stp) begin
            next_s.cnt[g] = s.cnt[g] + 8'h1;
         end

         // Settings reload at the period boundary, or on every tick under code 11, so a
         // running period of codes 00 to 10 is never cut short or stretched by a write in its middle
         if ((tick & gen_full[g]) | (stp & gen_wrap[g])) begin
            next_s.act_duty[g] = s.duty[g];
            next_s.act_div[g]  = s.div[g];
         end

         // An idle generator has no period to finish: it takes new settings
         // at once and restarts from the top, so a newly mapped channel
         // always sees whole periods
         if (!gen_used[g]) begin
            next_s.act_duty[g] = s.duty[g];
            next_s.act_div[g]  = s.div[g];
            next_s.cnt[g]      = 8'h0;
            next_s.pre[g]      = 2'h0;
         end

         // Level is registered; duty 8'hff still leaves one low step
         next_s.lvl[g] = gen_full[g]
                       | (s.cnt[g] < s.act_duty[g]);
      end

      // Channel state: ready follows its command, latched waits for the host,
      // wait counts out the restart delay of an inrush channel.
      // A trip only ever removes a gate; the end of a restart wait or a host clear can switch one back on.
      for (int i = 0; i < 8; i++) begin
         cmd = chan_cmd[i];
         next_s.cmd_q[i] = cmd;

         unique case (s.ch[i])
            CH_READY: begin
               if (trip[i]) begin
                  next_s.rtim[i] = 20'h0;
                  if (s.bulb_inrush_mode[i]) begin
                     next_s.ch[i] = CH_WAIT;
                  end else begin
                     next_s.ch[i] = CH_LATCHED;
                  end
               end
            end
            CH_WAIT: begin
               // Restart is automatic; the host need not clear anything
               next_s.rtim[i] = s.rtim[i] + 20'h1;
               if (rst_done[i]) begin
                  next_s.ch[i] = CH_READY;
               end
            end
            CH_LATCHED: begin
               // Only the host's clear brings the channel back
               if (clr_req[i]) begin
                  next_s.ch[i] = CH_READY;
               end
            end
            default: begin
               next_s.ch[i] = CH_READY;
            end
         endcase

         // Gate follows command and channel state; inverse current is not an input here,
         // so a channel keeps its on or off state while current flows back
         next_s.gate[i] = cmd & (next_s.ch[i] == CH_READY);

         // Hardware set wins over a clear in the same cycle; a flag alone
         // never latches an inrush channel, the state machine decides that
         if (err_set[i]) begin
            next_s.err[i] = 1'b1;
         end

         // Inrush window restarts at switch-on and runs while the bit is set.
         // A protection trip is no commanded switch-off, so the bit and its
         // window survive the restart wait.
         if (sw_on[i]) begin
            next_s.wtim[i] = 20'h0;
         end else if (s.bulb_inrush_mode[i]) begin
            next_s.wtim[i] = s.wtim[i] + 20'h1;
            if (win_done[i]) begin
               next_s.bulb_inrush_mode[i] = 1'b0;
            end
         end
         if (sw_off[i]) begin
            next_s.bulb_inrush_mode[i] = 1'b0;
         end
      end

      // Software set of inrush bits wins over hardware clear; a host that
      // arms a channel in the cycle of its switch-off keeps the bit, and
      // must rewrite it after any later switch-off
      // Software set of inrush bits wins over hardware clear
      if (wr & (s.dp_idx == `CPP_OFS_INRUSH)) begin
         next_s.bulb_inrush_mode = wd[7:0];
      end
   end

   // Asynchronous reset clears all state; only the trim code comes up at
   // nominal and the bus reports ready, so a master may start at the first
   // edge after release.
   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         s        <= '0;
         s.trim   <= `CPP_TRIM_RST;
         s.hready <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // Every output is a flip-flop of the state, free of glitches
   assign O_HRDATA    = s.hrdata;
   assign O_HREADYOUT = s.hready;
   assign O_HRESP     = s.hresp;
   assign O_GATE      = s.gate;
   assign O_ERR       = s.err;

endmodule : cpp_chan_ctrl

//--- bench/cpp_chan_props_properties.sv
// Port assertions of the channel protection and PWM logic
`timescale 1ns/1ns
module cpp_chan_props #(
   parameter int BIM_WIN_CYC = 200,
   parameter int RESTART_CYC = 50
) (
   input wire logic        I_SYS_CLK,
   input wire logic        I_RSTN,
   input wire logic        I_HSEL,
   input wire logic [1:0]  I_HTRANS,
   input wire logic        I_HWRITE,
   input wire logic        I_HREADY,
   input wire logic [7:0]  I_OVERLOAD,
   input wire logic [7:0]  I_OVERTEMP,
   input wire logic [7:0]  I_INVERSE,
   input wire logic [31:0] O_HRDATA,
   input wire logic        O_HREADYOUT,
   input wire logic        O_HRESP,
   input wire logic [7:0]  O_GATE,
   input wire logic [7:0]  O_ERR
);
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_RSTN);
   sequence s_trip0;
      O_GATE[0] && !I_INVERSE[0] && I_OVERLOAD[0];
   endsequence
   sequence s_hot2;
      O_GATE[2] && !I_INVERSE[2] && I_OVERTEMP[2];
   endsequence
   property p_rdy; O_HREADYOUT; endproperty
   property p_okay; !O_HRESP; endproperty
   property p_rdidle;
      !$past(I_HSEL && I_HTRANS[1] && I_HREADY && !I_HWRITE) |-> O_HRDATA == 32'h0;
   endproperty
   property p_off; s_trip0 |=> !O_GATE[0] [*2]; endproperty
   property p_err; s_trip0 |=> O_ERR[0]; endproperty
   property p_off2; s_hot2 |=> $fell(O_GATE[2]); endproperty
   property p_inv; O_GATE[0] && I_INVERSE[0] && I_OVERTEMP[0] |=> O_ERR[0]; endproperty
   // An error flag may only come up on a channel that was on
   property p_erron; (O_ERR & ~$past(O_ERR) & ~$past(O_GATE)) == 8'h0; endproperty
   a_rdy: assert property (p_rdy) else $error("hready low");
   a_okay: assert property (p_okay) else $error("response not okay");
   a_rdidle: assert property (p_rdidle) else $error("read data outside data phase");
   a_off: assert property (p_off) else $error("overload did not latch off");
   a_err: assert property (p_err) else $error("overload set no error");
   a_off2: assert property (p_off2) else $error("overheat did not switch off");
   a_inv: assert property (p_inv) else $error("inverse overheat set no error");
   a_erron: assert property (p_erron) else $error("error on channel that was off");
endmodule : cpp_chan_props

bind cpp_chan_ctrl cpp_chan_props #(.BIM_WIN_CYC(BIM_WIN_CYC), .RESTART_CYC(RESTART_CYC))
   PROPS (.I_SYS_CLK(I_SYS_CLK), .I_RSTN(I_RSTN), .I_HSEL(I_HSEL), .I_HTRANS(I_HTRANS),
   .I_HWRITE(I_HWRITE), .I_HREADY(I_HREADY), .I_OVERLOAD(I_OVERLOAD),
   .I_OVERTEMP(I_OVERTEMP), .I_INVERSE(I_INVERSE), .O_HRDATA(O_HRDATA),
   .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .O_GATE(O_GATE), .O_ERR(O_ERR));

//--- bench/cpp_stage_model.sv
// Power stage model: turns bench fault requests into detect lines
`timescale 1ns/1ns
module cpp_stage_model (
   input  wire logic [7:0] i_gate,
   input  wire logic [7:0] i_short,
   input  wire logic [7:0] i_hot,
   input  wire logic [7:0] i_rev,
   output logic      [7:0] o_ovl,
   output logic      [7:0] o_ovt,
   output logic      [7:0] o_inv
);
   // A shorted load only draws overload current while its stage is on
   assign o_ovl = i_gate & i_short;
   assign o_ovt = i_hot;
   assign o_inv = i_rev;
endmodule : cpp_stage_model

//--- bench/tb_channel_protect_pwm_logic.sv
// Testbench of the channel protection and PWM logic
`timescale 1ns/1ns
`include "cpp_map.svh"
module tb_channel_protect_pwm_logic;
   import cpp_pkg::*;
   localparam int WIN = 200;
   localparam int RST = 50;
   logic        clk, rstn, hsel, hwrite, hrdy, hresp;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, rd, d;
   logic [7:0]  gate, err, ovl, ovt, inv, shrt, hot, rev;
   int          errors, cmp_count, a;
   cpp_chan_ctrl #(.BIM_WIN_CYC(WIN), .RESTART_CYC(RST)) DUT (.I_SYS_CLK(clk),
      .I_RSTN(rstn), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
      .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hrdy), .I_OVERLOAD(ovl),
      .I_OVERTEMP(ovt), .I_INVERSE(inv), .O_HRDATA(hrdata), .O_HREADYOUT(hrdy),
      .O_HRESP(hresp), .O_GATE(gate), .O_ERR(err));
   cpp_stage_model STG (.i_gate(gate), .i_short(shrt), .i_hot(hot), .i_rev(rev),
      .o_ovl(ovl), .o_ovt(ovt), .o_inv(inv));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         errors++;
         $display("mismatch %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [5:0] ix, input logic [31:0] wd);
      hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, ix, 2'h0};
      do @(posedge clk); while (hrdy !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
      do @(posedge clk); while (hrdy !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask : wt
   // First channel of pair bit k; its partner is two channels up
   function automatic int pch(input int k);
      return (k & 1) | ((k & 2) << 1);
   endfunction : pch
   task automatic clr();
      shrt <= 8'h0; hot <= 8'h0; rev <= 8'h0;
      bus(1'b1, `CPP_OFS_OUTCTL, 32'h0);
      bus(1'b1, `CPP_OFS_LCLR, 32'hff);
      bus(1'b1, `CPP_OFS_STATUS, 32'hff00);
      bus(1'b1, `CPP_OFS_PAIR, 32'h0);
      bus(1'b1, `CPP_OFS_INRUSH, 32'h0);
   endtask : clr
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict
   initial begin
      wt(12000);
      errors++;
      give_verdict();
   end
   initial begin
      void'($urandom(32'h023ebf36));
      errors = 0; cmp_count = 0; rstn = 1'b0; hsel = 1'b0; htrans = 2'h0; hwrite = 1'b0;
      haddr = 32'h0; hwdata = 32'h0; shrt = 8'h0; hot = 8'h0; rev = 8'h0;
      wt(8);
      rstn <= 1'b1;
      wt(1);
      bus(1'b0, `CPP_OFS_TRIM, 32'h0); chk("trim", rd, 32'h8);
      bus(1'b0, 6'h3f, 32'h0); chk("unmapped", rd, 32'h0);
      d = $urandom() & 32'h3ff;
      bus(1'b1, `CPP_OFS_PWM0, d);
      bus(1'b0, `CPP_OFS_PWM0, 32'h0); chk("pwm0", rd, d);
      d = ($urandom() % 15) + 1;
      bus(1'b1, `CPP_OFS_TRIM, d);
      bus(1'b0, `CPP_OFS_TRIM, 32'h0); chk("trimrw", rd, d);
      for (int k = 0; k < 4; k++) begin
         a = pch(k);
         bus(1'b1, `CPP_OFS_PAIR, 32'h1 << k);
         bus(1'b1, `CPP_OFS_OUTCTL, 32'h1 << a); wt(3);
         chk("solo", gate, 32'h1 << a);
         bus(1'b1, `CPP_OFS_OUTCTL, 32'h5 << a); wt(3);
         hot <= 8'h4 << a; wt(3);
         chk("pair", gate, 32'h0);
         chk("perr", err[a + 2], 32'h1);
         clr();
      end
      bus(1'b1, `CPP_OFS_OUTCTL, 32'h1); wt(3);
      shrt <= 8'h1; wt(2); shrt <= 8'h0; wt(20);
      chk("latch", gate, 32'h0);
      bus(1'b1, `CPP_OFS_LCLR, 32'h1); wt(3);
      chk("relaunch", gate, 32'h1);
      clr();
      bus(1'b1, `CPP_OFS_INRUSH, 32'h2);
      bus(1'b1, `CPP_OFS_OUTCTL, 32'h2); wt(3);
      shrt <= 8'h2; wt(2); shrt <= 8'h0; wt(2);
      chk("rsoff", gate, 32'h0);
      wt(RST + 5); chk("rson", gate, 32'h2);
      bus(1'b0, `CPP_OFS_INRUSH, 32'h0); chk("bimset", rd, 32'h2);
      wt(WIN); bus(1'b0, `CPP_OFS_INRUSH, 32'h0); chk("bimend", rd, 32'h0);
      clr();
      bus(1'b1, `CPP_OFS_INRUSH, 32'h2);
      bus(1'b1, `CPP_OFS_OUTCTL, 32'h2);
      bus(1'b1, `CPP_OFS_OUTCTL, 32'h0); wt(2);
      bus(1'b0, `CPP_OFS_INRUSH, 32'h0); chk("bimoff", rd, 32'h0);
      bus(1'b1, `CPP_OFS_OUTCTL, 32'h1); wt(3);
      rev <= 8'h1; shrt <= 8'h1; wt(5);
      chk("invovl", {err, gate}, 32'h1);
      hot <= 8'h1; wt(3);
      chk("invot", {err, gate}, 32'h101);
      clr();
      bus(1'b1, `CPP_OFS_PWMMAP, 32'h10);
      bus(1'b1, `CPP_OFS_PWM1, 32'h300 | ($urandom() & 32'hff));
      bus(1'b1, `CPP_OFS_PWM0, 32'h300);
      bus(1'b1, `CPP_OFS_PWMOUT, 32'h30); wt(600);
      chk("full", gate, 32'h30);
      bus(1'b0, `CPP_OFS_STATUS, 32'h0); chk("lvl", rd, 32'h30030);
      bus(1'b1, `CPP_OFS_PWM0, 32'h200); wt(600);
      chk("dutyoff", gate, 32'h10);
      give_verdict();
   end
endmodule : tb_channel_protect_pwm_logic
